// ---- rtl/ebwsc_top.sv ----
/*
 * external bus wait-state control: control register on avalon-mm, bus
 * request and ownership, and sram access strobe timing per area.
 * assumes area match and dram type come from the attribute match logic,
 * inputs are synchronous to sys_clk, and dram cycles finish elsewhere.
 */
// The address map and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ebwsc_top #(
   parameter int unsigned ADDR_W = 4
) (
   // clock, reset, enable
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic ce,
   // avalon-mm register slave
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [ebwsc_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [ebwsc_pkg::BE_W-1:0] avs_byteenable,
   output logic [ebwsc_pkg::DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   // core access request
   input wire logic acc_req,
   input wire logic acc_write,
   input wire logic [ebwsc_pkg::AREA_N-1:0] area_match,
   input wire logic [ebwsc_pkg::AREA_N-1:0] area_dram,
   output logic acc_done,
   output logic rd_sample,
   // external bus arbiter
   input wire logic bus_grant,
   output logic bus_request_out,
   // external sram strobes
   output logic mem_cs_n,
   output logic mem_oe_n,
   output logic mem_we_n
);
   import ebwsc_pkg::*;

   generate
      if (ADDR_W < 2 || ADDR_W > DATA_W) begin : g_bad_addr
         $error("ebwsc_top: ADDR_W must lie in 2..32");
      end
      // byte lanes must tile the register and the bus
      if (REG_W % 8 != 0 || BE_W * 8 != DATA_W) begin : g_bad_lane
         $error("ebwsc_top: byte lane layout does not fit");
      end
   endgenerate

   // wait count of one field, zero-extended
   function automatic logic [WAIT_W-1:0] field_wait(
      input logic [REG_W-1:0] cfg, input int unsigned sel);
      logic [WAIT_W-1:0] w;
      w = '0;
      unique case (sel)
         0: w = cfg[A0_LSB +: WIDE_W];
         1: w = cfg[A1_LSB +: WIDE_W];
         2: w = {2'h0, cfg[A2_LSB +: NARROW_W]};
         3: w = {2'h0, cfg[A3_LSB +: NARROW_W]};
         default: w = cfg[DFLT_LSB +: WIDE_W];
      endcase
      return w;
   endfunction

   // trailing waits for a given wait count
   function automatic logic [1:0] trail_of(input logic [WAIT_W-1:0] w);
      logic [1:0] t;
      t = TRAIL_NONE;
      if (w >= TRAIL_TWO_MIN) begin
         t = TRAIL_TWO;
      end else if (w >= TRAIL_ONE_MIN) begin
         t = TRAIL_ONE;
      end
      return t;
   endfunction

   // register slave state
   logic [REG_W-1:0] cfg_ff, nxt_cfg;
   logic owner_ff, nxt_owner;
   logic wait_ff, nxt_wait;
   logic [DATA_W-1:0] rdata_ff, nxt_rdata;
   logic addr_hit;
   logic [REG_W-1:0] readback;
   logic [REG_W-1:0] merged;

   assign addr_hit = (avs_address == CTRL_OFS[ADDR_W-1:0]);

   always_comb begin
      readback = cfg_ff & CTRL_WR_MASK;
      readback[OWNER_BIT] = owner_ff;
      readback[RSVD_BIT] = 1'b0;
   end

   // byte-lane merge of write data
   genvar gb;
   generate
      for (gb = 0; gb < REG_W / 8; gb++) begin : g_lane
         assign merged[gb*8 +: 8] = avs_byteenable[gb] ?
            avs_writedata[gb*8 +: 8] : cfg_ff[gb*8 +: 8];
      end
   endgenerate

   always_comb begin
      nxt_wait = 1'b1;
      nxt_rdata = rdata_ff;
      nxt_cfg = cfg_ff;
      // answer one cycle after the request is seen
      if ((avs_read || avs_write) && wait_ff) begin
         nxt_wait = 1'b0;
      end
      if (avs_read && wait_ff) begin
         nxt_rdata = addr_hit ? {8'h00, readback} : '0;
      end
      if (avs_write && !wait_ff && addr_hit) begin
         nxt_cfg = merged & CTRL_WR_MASK;
      end
      nxt_owner = bus_grant;
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cfg_ff <= CTRL_RST;
         owner_ff <= 1'b0;
         wait_ff <= 1'b1;
         rdata_ff <= '0;
      end else if (ce) begin
         cfg_ff <= nxt_cfg;
         owner_ff <= nxt_owner;
         wait_ff <= nxt_wait;
         rdata_ff <= nxt_rdata;
      end
   end

   assign avs_readdata = rdata_ff;
   assign avs_waitrequest = wait_ff;

   // area selection
   logic [WAIT_W-1:0] sel_wait;
   logic sel_dram;

   always_comb begin
      sel_wait = field_wait(cfg_ff, AREA_N);
      sel_dram = 1'b0;
      for (int i = AREA_N - 1; i >= 0; i--) begin
         if (area_match[i]) begin
            sel_wait = field_wait(cfg_ff, i);
            sel_dram = area_dram[i];
         end
      end
   end

   // access sequencer
   ebwsc_wait_if wif ();

   ebwsc_wait_timer u_timer (
      .sys_clk (sys_clk),
      .nrst (nrst),
      .ce (ce),
      .tif (wif.tmr)
   );

   ebwsc_state_t state_ff, nxt_state;
   logic [WAIT_W-1:0] ws_ff, nxt_ws;
   logic [1:0] trail_ff, nxt_trail;
   logic wr_ff, nxt_wr;
   logic req_ff, nxt_req;
   logic done_ff, nxt_done;
   logic smp_ff, nxt_smp;
   logic cs_n_ff, nxt_cs_n;
   logic oe_n_ff, nxt_oe_n;
   logic we_n_ff, nxt_we_n;

   always_comb begin
      nxt_state = state_ff;
      nxt_ws = ws_ff;
      nxt_trail = trail_ff;
      nxt_wr = wr_ff;
      nxt_smp = 1'b0;
      wif.load = 1'b0;
      wif.count = '0;
      unique case (state_ff)
         ST_IDLE: begin
            // dram cycles are not timed here
            if (acc_req && !sel_dram) begin
               nxt_state = ST_ARB;
               nxt_ws = sel_wait;
               nxt_trail = trail_of(sel_wait);
               nxt_wr = acc_write;
            end
         end
         ST_ARB: begin
            if (bus_grant) begin
               // strobe length from the latched wait count
               nxt_state = ST_STROBE;
               wif.load = 1'b1;
               wif.count = ws_ff;
               nxt_smp = !wr_ff && (ws_ff == '0);
            end
         end
         ST_STROBE: begin
            // sample set by wait count, on reads only
            nxt_smp = !wr_ff && wif.one;
            if (wif.zero) begin
               if (trail_ff == TRAIL_NONE) begin
                  nxt_state = ST_DONE;
               end else begin
                  nxt_state = ST_TRAIL;
                  wif.load = 1'b1;
                  wif.count = WAIT_W'(trail_ff - 2'h1);
               end
            end
         end
         ST_TRAIL: begin
            // chip select only, data hold and release
            if (wif.zero) begin
               nxt_state = ST_DONE;
            end
         end
         ST_DONE: begin
            // one-cycle completion pulse
            nxt_state = ST_IDLE;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   // registered strobes follow the next state
   always_comb begin
      nxt_cs_n = !(nxt_state == ST_STROBE || nxt_state == ST_TRAIL);
      nxt_oe_n = !(nxt_state == ST_STROBE && !nxt_wr);
      nxt_we_n = !(nxt_state == ST_STROBE && nxt_wr);
      nxt_done = (nxt_state == ST_DONE);
      // else only while attempted or pending
      nxt_req = cfg_ff[HOLD_BIT] || (acc_req && nxt_state != ST_DONE) ||
         nxt_state == ST_ARB || nxt_state == ST_STROBE ||
         nxt_state == ST_TRAIL;
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_ff <= ST_IDLE;
         ws_ff <= '0;
         trail_ff <= TRAIL_NONE;
         wr_ff <= 1'b0;
         req_ff <= 1'b0;
         done_ff <= 1'b0;
         smp_ff <= 1'b0;
         cs_n_ff <= 1'b1;
         oe_n_ff <= 1'b1;
         we_n_ff <= 1'b1;
      end else if (ce) begin
         state_ff <= nxt_state;
         ws_ff <= nxt_ws;
         trail_ff <= nxt_trail;
         wr_ff <= nxt_wr;
         req_ff <= nxt_req;
         done_ff <= nxt_done;
         smp_ff <= nxt_smp;
         cs_n_ff <= nxt_cs_n;
         oe_n_ff <= nxt_oe_n;
         we_n_ff <= nxt_we_n;
      end
   end

   assign bus_request_out = req_ff;
   assign acc_done = done_ff;
   assign rd_sample = smp_ff;
   assign mem_cs_n = cs_n_ff;
   assign mem_oe_n = oe_n_ff;
   assign mem_we_n = we_n_ff;
endmodule // ebwsc_top
`default_nettype wire

// ---- rtl/ebwsc_wait_timer.sv ----
/*
 * wait-state down-counter: loads a count, steps down to zero, holds there.
 * assumes a load pulse from the sequencer on state entry.
 */
`timescale 1ns/1ps
`default_nettype none
module ebwsc_wait_timer (
   // clock, reset, enable
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic ce,
   // sequencer side
   ebwsc_wait_if.tmr tif
);
   import ebwsc_pkg::*;

   logic [WAIT_W-1:0] cnt_ff;
   logic [WAIT_W-1:0] nxt_cnt;

   always_comb begin
      nxt_cnt = cnt_ff;
      if (tif.load) begin
         nxt_cnt = tif.count;
      end else if (cnt_ff != '0) begin
         nxt_cnt = cnt_ff - 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_ff <= '0;
      end else if (ce) begin
         cnt_ff <= nxt_cnt;
      end
   end

   assign tif.zero = (cnt_ff == '0);
   assign tif.one = (cnt_ff == WAIT_W'(1));
endmodule // ebwsc_wait_timer
`default_nettype wire

// ---- shared/ebwsc_pkg.sv ----
/*
 * constants, field layout, reset value and state codes for the external
 * bus wait-state control block.
 * assumes nothing of its surroundings; imported by the rtl, property and bench files.
 */
package ebwsc_pkg;
   // bus and register widths
   localparam int unsigned DATA_W = 32;
   localparam int unsigned REG_W = 24;
   localparam int unsigned BE_W = 4;
   localparam int unsigned WAIT_W = 5;
   localparam int unsigned AREA_N = 4;

   // register offset (byte address)
   localparam logic [31:0] CTRL_OFS = 32'h0000_0000;

   // field positions
   localparam int unsigned HOLD_BIT = 23;
   localparam int unsigned RSVD_BIT = 22;
   localparam int unsigned OWNER_BIT = 21;
   localparam int unsigned DFLT_LSB = 16;
   localparam int unsigned A3_LSB = 13;
   localparam int unsigned A2_LSB = 10;
   localparam int unsigned A1_LSB = 5;
   localparam int unsigned A0_LSB = 0;
   localparam int unsigned WIDE_W = 5;
   localparam int unsigned NARROW_W = 3;

   // reset value and writable bits
   localparam logic [23:0] CTRL_RST = 24'h1F_FFFF;
   localparam logic [23:0] CTRL_WR_MASK = 24'h9F_FFFF;

   // trailing wait thresholds and counts
   localparam logic [4:0] TRAIL_ONE_MIN = 5'h04;
   localparam logic [4:0] TRAIL_TWO_MIN = 5'h08;
   localparam logic [1:0] TRAIL_NONE = 2'h0;
   localparam logic [1:0] TRAIL_ONE = 2'h1;
   localparam logic [1:0] TRAIL_TWO = 2'h2;

   // access sequencer states
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_ARB = 5'h02,
      ST_STROBE = 5'h04,
      ST_TRAIL = 5'h08,
      ST_DONE = 5'h10
   } ebwsc_state_t;
endpackage : ebwsc_pkg

// ---- shared/ebwsc_wait_if.sv ----
/*
 * link between the access sequencer and its wait-state down-counter.
 * assumes both ends run on the same clock and clock enable.
 */
`timescale 1ns/1ps
`default_nettype none
interface ebwsc_wait_if;
   logic load;
   logic [ebwsc_pkg::WAIT_W-1:0] count;
   logic zero;
   logic one;

   modport ctl (output load, output count, input zero, input one);
   modport tmr (input load, input count, output zero, output one);
endinterface : ebwsc_wait_if
`default_nettype wire

// ---- verif/ebwsc_bus_partner.sv ----
/* arbiter model: grants the bus one or four edges after a request.
   assumes request and grant share sys_clk. */
`timescale 1ns/1ps
`default_nettype none
module ebwsc_bus_partner (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // arbiter side
   input wire logic slow,
   input wire logic bus_request_out,
   output logic bus_grant
);
   logic [2:0] wait_ff, nxt_wait;
   logic nxt_grant;
   // grant follows request, drops with it
   always_comb begin
      nxt_wait = bus_request_out ? wait_ff + 3'h1 : 3'h0;
      if (wait_ff == 3'h7) nxt_wait = wait_ff;
      nxt_grant = bus_request_out && (!slow || wait_ff >= 3'h3);
   end
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         wait_ff <= 3'h0;
         bus_grant <= 1'b0;
      end else begin
         wait_ff <= nxt_wait;
         bus_grant <= nxt_grant;
      end
   end
endmodule // ebwsc_bus_partner
`default_nettype wire

// ---- verif/ebwsc_top_properties.sv ----
/* port assertions for the wait-state control block.
   assumes all byte lanes held high; ce drops only while idle. */
`timescale 1ns/1ps
`default_nettype none
module ebwsc_top_properties #(
   parameter int unsigned ADDR_W = 4
) (
   // clock, reset, enable
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic ce,
   // register bus
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [ebwsc_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [ebwsc_pkg::DATA_W-1:0] avs_readdata,
   input wire logic avs_waitrequest,
   // access and memory side
   input wire logic acc_req,
   input wire logic [ebwsc_pkg::AREA_N-1:0] area_match,
   input wire logic [ebwsc_pkg::AREA_N-1:0] area_dram,
   input wire logic acc_done,
   input wire logic rd_sample,
   input wire logic bus_request_out,
   input wire logic mem_cs_n,
   input wire logic mem_oe_n,
   input wire logic mem_we_n
);
   import ebwsc_pkg::*;
   logic hold_ff, nxt_hold;
   wire logic trail = !mem_cs_n && mem_oe_n && mem_we_n;
   // shadow of the hold bit
   always_comb begin
      nxt_hold = hold_ff;
      if (ce && avs_write && !avs_waitrequest && avs_address == '0)
         nxt_hold = avs_writedata[HOLD_BIT];
   end
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) hold_ff <= 1'b0;
      else hold_ff <= nxt_hold;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   a_hold_keeps_req: assert property (hold_ff |=> bus_request_out)
      else $error("request low while hold set");
   a_idle_no_req: assert property (
      (!hold_ff && !acc_req && mem_cs_n)[*2] |=> !bus_request_out)
      else $error("request high while idle");
   a_ack_one_cycle: assert property (
      ce && (avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("waitrequest timing wrong");
   a_rsvd_reads_zero: assert property (
      avs_readdata[31:24] == 8'h00 && !avs_readdata[RSVD_BIT])
      else $error("reserved read bits set");
   a_sample_last: assert property (rd_sample |-> !mem_oe_n ##1 mem_oe_n)
      else $error("read sample not in last strobe");
   a_trail_max_two: assert property (trail ##1 trail |=> !trail)
      else $error("more than two trailing waits");
   a_done_on_release: assert property (
      $rose(mem_cs_n) |-> acc_done ##1 !acc_done)
      else $error("done not with release");
   a_dram_quiet: assert property (
      (acc_req && area_match == 4'h4 && area_dram[2])[*2] |-> mem_cs_n)
      else $error("strobe on dram area");
   cover property (rd_sample);
   cover property (trail ##1 trail);
   cover property (hold_ff && bus_request_out && !acc_req);
endmodule // ebwsc_top_properties
bind ebwsc_top ebwsc_top_properties #(.ADDR_W(ADDR_W)) u_props (.sys_clk,
   .nrst, .ce, .avs_address, .avs_read, .avs_write, .avs_writedata,
   .avs_readdata, .avs_waitrequest, .acc_req, .area_match, .area_dram,
   .acc_done, .rd_sample, .bus_request_out, .mem_cs_n, .mem_oe_n,
   .mem_we_n);
`default_nettype wire

// ---- verif/tb_ebwsc_top.sv ----
/* self-checking bench for the wait-state control block.
   assumes the arbiter model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_ebwsc_top;
   import ebwsc_pkg::*;
   typedef struct {logic [23:0] cfg; logic [3:0] mt; logic [3:0] dr;
      logic wr; logic sl; int ns; int nc;} ebwsc_row_t;
   logic sys_clk, nrst, ce, avs_read, avs_write, acc_req, acc_write, slow;
   logic [3:0] avs_address, area_match, area_dram, avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic avs_waitrequest, acc_done, rd_sample, bus_grant, bus_request_out;
   logic mem_cs_n, mem_oe_n, mem_we_n;
   int failures, checks_done, ns, nc, nr, i;
   ebwsc_row_t rows [11] = '{
      '{24'h08_7C81, 4'h1, 4'h0, 1'b0, 1'b0, 2, 2},
      '{24'h08_7C81, 4'h2, 4'h0, 1'b1, 1'b0, 5, 6},
      '{24'h08_7C81, 4'h4, 4'h0, 1'b0, 1'b1, 8, 9},
      '{24'h08_7C81, 4'h8, 4'h0, 1'b1, 1'b0, 4, 4},
      '{24'h08_7C81, 4'h0, 4'hF, 1'b0, 1'b0, 9, 11},
      '{24'h08_7C81, 4'h3, 4'h0, 1'b0, 1'b0, 2, 2},
      '{24'h1F_33E7, 4'h1, 4'h0, 1'b1, 1'b0, 8, 9},
      '{24'h1F_33E7, 4'h2, 4'h0, 1'b0, 1'b0, 32, 34},
      '{24'h1F_33E7, 4'h4, 4'h0, 1'b1, 1'b0, 5, 6},
      '{24'h1F_33E7, 4'h8, 4'h4, 1'b0, 1'b0, 2, 2},
      '{24'h1F_33E7, 4'h0, 4'h0, 1'b1, 1'b1, 32, 34}};
   ebwsc_top u_ebwsc_top (.sys_clk, .nrst, .ce, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
      .avs_waitrequest, .acc_req, .acc_write, .area_match, .area_dram,
      .acc_done, .rd_sample, .bus_grant, .bus_request_out, .mem_cs_n,
      .mem_oe_n, .mem_we_n);
   ebwsc_bus_partner u_ebwsc_bus_partner (.sys_clk, .nrst, .slow,
      .bus_request_out, .bus_grant);
   task automatic results;
      if (failures == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic bound(input int n);
      if (n >= 200) begin
         failures++;
         results();
      end
   endtask
   task automatic bus(input logic r, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] rd);
      int k;
      @(posedge sys_clk);
      avs_read <= r;
      avs_write <= !r;
      avs_address <= a;
      avs_writedata <= d;
      for (k = 0; k < 200; k++) begin
         @(posedge sys_clk);
         if (avs_waitrequest === 1'b0) break;
      end
      bound(k);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic access(input ebwsc_row_t w);
      int k;
      ns = 0;
      nc = 0;
      nr = 0;
      @(posedge sys_clk);
      acc_req <= 1'b1;
      acc_write <= w.wr;
      area_match <= w.mt;
      area_dram <= w.dr;
      for (k = 0; k < 200; k++) begin
         @(negedge sys_clk);
         ns += ((w.wr ? mem_we_n : mem_oe_n) === 1'b0);
         nc += (mem_cs_n === 1'b0);
         nr += (rd_sample === 1'b1);
         if (acc_done === 1'b1) break;
      end
      bound(k);
      @(posedge sys_clk);
      acc_req <= 1'b0;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   initial begin
      {nrst, avs_read, avs_write, acc_req, acc_write, slow} = '0;
      {avs_address, area_match, area_dram, avs_writedata} = '0;
      ce = 1'b1;
      avs_byteenable = 4'hF;
      failures = 0;
      checks_done = 0;
      repeat (12) @(posedge sys_clk);
      nrst <= 1'b1;
      foreach (rows[j]) begin
         bus(1'b0, 4'h0, {8'h00, rows[j].cfg}, q);
         slow <= rows[j].sl;
         access(rows[j]);
         chk(ns, rows[j].ns);
         chk(nc, rows[j].nc);
         chk(nr, {31'h0, !rows[j].wr});
      end
      @(posedge sys_clk);
      nrst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      ce <= 1'b0;
      avs_read <= 1'b1;
      repeat (4) @(posedge sys_clk);
      chk(avs_waitrequest, 1'b1);
      ce <= 1'b1;
      bus(1'b1, 4'h0, 32'h0, q);
      chk(q, 32'h001F_FFFF);
      bus(1'b0, 4'h0, 32'hFFFF_FFFF, q);
      for (i = 0; i < 200 && bus_grant !== 1'b1; i++) @(negedge sys_clk);
      bound(i);
      bus(1'b0, 4'h8, 32'h0000_0000, q);
      bus(1'b1, 4'h0, 32'h0, q);
      chk(q, 32'h00BF_FFFF);
      chk(bus_request_out, 1'b1);
      bus(1'b1, 4'h4, 32'h0, q);
      chk(q, 32'h0000_0000);
      bus(1'b0, 4'h0, 32'h001F_FFFF, q);
      for (i = 0; i < 200 && bus_request_out !== 1'b0; i++)
         @(negedge sys_clk);
      bound(i);
      @(posedge sys_clk);
      acc_req <= 1'b1;
      area_match <= 4'h4;
      area_dram <= 4'h4;
      ns = 0;
      repeat (8) begin
         @(negedge sys_clk);
         ns += ((mem_cs_n & !acc_done) !== 1'b1);
      end
      chk(ns, 0);
      chk(bus_request_out, 1'b1);
      @(posedge sys_clk);
      acc_req <= 1'b0;
      results();
   end
endmodule // tb_ebwsc_top
`default_nettype wire
